// ### flash_image_loader.sv
// Flash image loader: page select, passive serial configuration, APB registers
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module flash_image_loader import loader_pkg::*; #(
    parameter int unsigned PAGE_WORDS = PAGE_WORDS_DEFAULT
) (
    // Clock and reset button
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    // Buttons, switch, jumper
    input  wire logic              image_load_button_n,
    input  wire logic              image_select_button_n,
    input  wire logic              boot_image_switch,
    input  wire logic              jtag_takeover_jumper_n,
    // Indicators
    output logic                   page_indicator_0_n,
    output logic                   page_indicator_1_n,
    output logic                   page_indicator_2_n,
    output logic                   load_active_led,
    output logic                   load_error_led,
    output logic                   factory_led,
    // Flash
    output flash_req_t             flash,
    input  wire logic [WORD_W-1:0] flash_data,
    // Target configuration pins
    output cfg_pins_t              cfg,
    input  wire logic              config_status_n,
    input  wire logic              config_done_flag,
    // Target JTAG takeover
    output jtag_pins_t             jtag,
    input  wire logic              jtag_tdo
);
    localparam int unsigned NIN = 7;

    logic [NIN-1:0]      raw_in;
    logic [NIN-1:0]      sync_in;
    logic [WORD_W-1:0]   data_sync;
    logic                load_n_s, sel_n_s, boot_sw, jumper_n_s, status_n_s, done_s, tdo_s;
    logic                load_n_d, sel_n_d, load_press, sel_press;
    load_state_t         st;
    logic [CNT_W-1:0]    cnt;
    logic [2:0]          ind_n;
    logic [1:0]          load_page;
    logic [FLASH_AW-1:0] addr;
    logic [31:0]         words_left;
    logic [WORD_W-1:0]   shreg;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic                sw_start, ce_n, oe_n, req_n, bit_clk, ser_data, jtag_oe;
    logic [IRQ_W-1:0]    irq_stat, irq_mask;
    logic [2:0]          jtag_out;
    logic                rd_acc, wr_acc, addr_ok, start_load;
    logic [IRQ_W-1:0]    events;

    assign raw_in = {image_load_button_n, image_select_button_n, boot_image_switch, jtag_takeover_jumper_n,
                     config_status_n, config_done_flag, jtag_tdo};
    assign {load_n_s, sel_n_s, boot_sw, jumper_n_s, status_n_s, done_s, tdo_s} = sync_in;

    sync_stages #(.W(NIN), .INIT(7'h7c)) u_sync_pins (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (raw_in),
        .q       (sync_in)
    );

    sync_stages #(.W(WORD_W), .INIT('0)) u_sync_data (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (flash_data),
        .q       (data_sync)
    );

    // Button press edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_n_d <= 1'b1;
            sel_n_d  <= 1'b1;
        end else begin
            load_n_d <= load_n_s;
            sel_n_d  <= sel_n_s;
        end
    end
    assign load_press = load_n_d & ~load_n_s;
    assign sel_press  = sel_n_d & ~sel_n_s;
    assign start_load = (st == ST_IDLE || st == ST_DONE || st == ST_ERROR) && (load_press || sw_start);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ind_n <= IND_RESET;
        end else if (st == ST_BOOT && cnt == CNT_W'(BOOT_WAIT_CYC)) begin
            ind_n <= boot_sw ? {IND_RESET[1:0], IND_RESET[2]} : IND_RESET;
        end else if (sel_press) begin
            ind_n <= {ind_n[1:0], ind_n[2]};
        end
    end
    assign page_indicator_0_n = ind_n[0];
    assign page_indicator_1_n = ind_n[1];
    assign page_indicator_2_n = ind_n[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st  <= ST_BOOT;
            cnt <= '0;
        end else begin
            case (st)
                ST_BOOT: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(BOOT_WAIT_CYC) + 1'b1) begin
                        st  <= ST_REQ;
                        cnt <= '0;
                    end
                end
                ST_IDLE, ST_DONE, ST_ERROR: begin
                    if (start_load) begin
                        st  <= ST_REQ;
                        cnt <= '0;
                    end
                end
                ST_REQ: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(REQ_LOW_CYC - 1)) begin
                        st  <= ST_WSTAT;
                        cnt <= '0;
                    end
                end
                ST_WSTAT: begin
                    cnt <= cnt + 1'b1;
                    if (cnt >= CNT_W'(SYNC_STAGES) && status_n_s) begin
                        st  <= ST_FETCH;
                        cnt <= '0;
                    end else if (cnt == CNT_W'(STATUS_TIMEOUT_CYC)) begin
                        st <= ST_ERROR;
                    end
                end
                ST_FETCH: begin
                    cnt <= cnt + 1'b1;
                    if (cnt == CNT_W'(FLASH_WAIT_CYC)) begin
                        st  <= ST_SHIFT;
                        cnt <= '0;
                    end
                end
                ST_SHIFT: begin
                    cnt <= (cnt == CNT_W'(BIT_HALF_CYC - 1)) ? '0 : cnt + 1'b1;
                    if (!status_n_s) begin
                        st <= ST_ERROR;
                    end else if (cnt == CNT_W'(BIT_HALF_CYC - 1) && cfg.bit_clock && bit_cnt == '1) begin
                        if (done_s) begin
                            st <= ST_DONE;
                        end else if (words_left == '0) begin
                            st <= ST_ERROR;
                        end else begin
                            st <= ST_FETCH;
                        end
                        cnt <= '0;
                    end
                end
                default: begin
                    st  <= ST_IDLE;
                    cnt <= '0;
                end
            endcase
        end
    end

    // Page latch, flash address and word count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_page  <= 2'h0;
            addr       <= PAGE0_BASE;
            words_left <= '0;
        end else if ((st == ST_BOOT && cnt == CNT_W'(BOOT_WAIT_CYC) + 1'b1) || start_load) begin
            load_page  <= !ind_n[0] ? 2'h0 : (!ind_n[1] ? 2'h1 : 2'h2);
            addr       <= !ind_n[0] ? PAGE0_BASE : (!ind_n[1] ? PAGE1_BASE : PAGE2_BASE);
            words_left <= PAGE_WORDS;
        end else if (st == ST_FETCH && cnt == CNT_W'(FLASH_WAIT_CYC)) begin
            addr       <= addr + 1'b1;
            words_left <= words_left - 1'b1;
        end
    end
    assign flash = {addr, ce_n, oe_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ce_n <= 1'b1;
            oe_n <= 1'b1;
        end else begin
            ce_n <= !(st == ST_FETCH && cnt < CNT_W'(FLASH_WAIT_CYC));
            oe_n <= !(st == ST_FETCH && cnt < CNT_W'(FLASH_WAIT_CYC));
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg    <= '0;
            bit_cnt  <= '0;
            bit_clk  <= 1'b0;
            ser_data <= 1'b0;
        end else if (st == ST_FETCH && cnt == CNT_W'(FLASH_WAIT_CYC)) begin
            shreg    <= data_sync >> 1;
            ser_data <= data_sync[0];
            bit_cnt  <= '0;
            bit_clk  <= 1'b0;
        end else if (st == ST_SHIFT && cnt == CNT_W'(BIT_HALF_CYC - 1)) begin
            bit_clk <= ~bit_clk;
            if (bit_clk && bit_cnt != '1) begin
                ser_data <= shreg[0];
                shreg    <= shreg >> 1;
                bit_cnt  <= bit_cnt + 1'b1;
            end
        end else if (st != ST_SHIFT) begin
            bit_clk <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_n <= 1'b1;
        end else begin
            req_n <= !(st == ST_BOOT && cnt == CNT_W'(BOOT_WAIT_CYC) + 1'b1) && !start_load
                     && !(st == ST_REQ && cnt != CNT_W'(REQ_LOW_CYC - 1));
        end
    end
    assign cfg = {req_n, bit_clk, ser_data};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_active_led <= 1'b0;
            load_error_led  <= 1'b0;
            factory_led     <= 1'b0;
        end else begin
            load_active_led <= st == ST_REQ || st == ST_WSTAT || st == ST_FETCH || st == ST_SHIFT;
            if (st == ST_REQ) begin
                load_error_led <= 1'b0;
                factory_led    <= 1'b0;
            end else if (st == ST_ERROR) begin
                load_error_led <= 1'b1;
            end else if (st == ST_DONE) begin
                factory_led <= load_page == 2'h0;
            end
        end
    end

    assign jtag = {jtag_out[JTAG_TCK], jtag_out[JTAG_TMS], jtag_out[JTAG_TDI], jtag_oe};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jtag_oe <= 1'b0;
        end else begin
            jtag_oe <= !jumper_n_s;
        end
    end

    // APB slave, zero wait states
    assign pready  = 1'b1;
    assign rd_acc  = psel && penable && !pwrite;
    assign wr_acc  = psel && penable && pwrite;
    assign addr_ok = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_IRQ_STAT
                     || paddr == REG_IRQ_MASK || paddr == REG_JTAG;
    assign pslverr = psel && penable && !addr_ok;
    assign events  = {st == ST_ERROR && load_active_led, st == ST_DONE && load_active_led};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_start <= 1'b0;
            irq_mask <= '0;
            jtag_out <= '0;
        end else begin
            sw_start <= wr_acc && paddr == REG_CTRL && pwdata[CTRL_START];
            if (wr_acc && paddr == REG_IRQ_MASK) begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
            if (wr_acc && paddr == REG_JTAG) begin
                jtag_out <= pwdata[JTAG_TDI:JTAG_TCK];
            end
        end
    end

    // Sticky events, read clears, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
            irq      <= 1'b0;
        end else begin
            irq_stat <= ((rd_acc && paddr == REG_IRQ_STAT) ? '0 : irq_stat) | events;
            irq      <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                REG_STATUS:   prdata <= {21'h0, tdo_s, !jumper_n_s, done_s, load_page, 3'h0,
                                         factory_led, load_error_led, load_active_led};
                REG_IRQ_STAT: prdata <= {30'h0, irq_stat | events};
                REG_IRQ_MASK: prdata <= {30'h0, irq_mask};
                REG_JTAG:     prdata <= {28'h0, tdo_s, jtag_out};
                default:      prdata <= '0;
            endcase
        end
    end

    // Checks
    sequence s_req_low;
        !cfg.request_n [*8];
    endsequence

    chk_req_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(st == ST_REQ) |-> s_req_low) else $error("request pulse too short");
    chk_status_wait: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_WSTAT && !status_n_s |=> st != ST_FETCH) else $error("fetch before status");
    chk_load_start: assert property (@(posedge pclk) disable iff (!presetn)
        (st == ST_IDLE || st == ST_DONE || st == ST_ERROR) && load_press |=> st == ST_REQ)
        else $error("load press ignored");
    chk_select_step: assert property (@(posedge pclk) disable iff (!presetn)
        sel_press && st != ST_BOOT |=> ind_n == {$past(ind_n[1:0]), $past(ind_n[2])}) else $error("bad step");
    chk_onehot_ind: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot(~ind_n)) else $error("indicators not one hot");
    chk_bit_stable: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cfg.bit_clock) |-> $stable(cfg.serial_data)) else $error("data moved on rising bit clock");
    chk_active_led: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_FETCH |=> load_active_led) else $error("active indicator dark");
    chk_error_led: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_ERROR |=> load_error_led) else $error("error indicator dark");
    chk_factory_led: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_DONE |=> factory_led == ($past(load_page) == 2'h0)) else $error("factory indicator wrong");
    chk_boot_page: assert property (@(posedge pclk) disable iff (!presetn)
        st == ST_BOOT ##1 st == ST_REQ |-> load_page == {1'b0, boot_sw}) else $error("wrong boot page");
    chk_jtag_take: assert property (@(posedge pclk) disable iff (!presetn)
        !jumper_n_s [*2] |-> jtag.oe) else $error("jtag not taken");
endmodule : flash_image_loader
`default_nettype wire

// ### loader_pkg.sv
// Shared constants and types for the flash image configuration loader
package loader_pkg;
    localparam int unsigned CLK_PERIOD_NS      = 40;
    localparam int unsigned REQ_LOW_NS         = 500;
    localparam int unsigned STATUS_TIMEOUT_NS  = 100000;
    localparam int unsigned BIT_HALF_NS        = 160;
    localparam int unsigned FLASH_ACCESS_NS    = 120;
    localparam int unsigned REQ_LOW_CYC        = (REQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STATUS_TIMEOUT_CYC = STATUS_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned BIT_HALF_CYC       = (BIT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_STAGES        = 2;
    localparam int unsigned FLASH_WAIT_CYC     = (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int unsigned BOOT_WAIT_CYC      = SYNC_STAGES + 1;
    localparam int unsigned CNT_W              = 12;
    localparam int unsigned FLASH_AW           = 25;
    localparam int unsigned WORD_W             = 16;
    localparam int unsigned BIT_CNT_W          = 4;

    // Word addresses of the three hardware pages
    localparam logic [FLASH_AW-1:0] PAGE0_BASE = 25'h0010000;
    localparam logic [FLASH_AW-1:0] PAGE1_BASE = 25'h0320000;
    localparam logic [FLASH_AW-1:0] PAGE2_BASE = 25'h0630000;
    localparam int unsigned PAGE_WORDS_DEFAULT = 32'h0310000;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_JTAG     = 8'h10;

    // Field positions
    localparam int unsigned CTRL_START   = 0;
    localparam int unsigned IRQ_DONE     = 0;
    localparam int unsigned IRQ_ERROR    = 1;
    localparam int unsigned IRQ_W        = 2;
    localparam int unsigned JTAG_TCK     = 0;
    localparam int unsigned JTAG_TMS     = 1;
    localparam int unsigned JTAG_TDI     = 2;
    localparam int unsigned JTAG_TDO     = 3;

    localparam logic [2:0] IND_RESET = 3'h6;

    typedef enum logic [2:0] {
        ST_BOOT  = 3'h0,
        ST_IDLE  = 3'h1,
        ST_REQ   = 3'h3,
        ST_WSTAT = 3'h2,
        ST_FETCH = 3'h6,
        ST_SHIFT = 3'h7,
        ST_DONE  = 3'h5,
        ST_ERROR = 3'h4
    } load_state_t;

    typedef struct packed {
        logic [FLASH_AW-1:0] addr;
        logic                ce_n;
        logic                oe_n;
    } flash_req_t;

    typedef struct packed {
        logic request_n;
        logic bit_clock;
        logic serial_data;
    } cfg_pins_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic oe;
    } jtag_pins_t;
endpackage : loader_pkg

// ### sync_stages.sv
// Two flip-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module sync_stages #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : sync_stages
`default_nettype wire

// ### fpga_flash_model.sv
// Behavioural flash array and passive serial configuration target
`timescale 1ns/1ps
`default_nettype none
module fpga_flash_model import loader_pkg::*; (
    // Loader side, and done word count from the bench
    input  wire logic              pclk,
    input  wire flash_req_t        flash,
    input  wire cfg_pins_t         cfg,
    input  wire logic [7:0]        done_words,
    // Target responses
    output logic      [WORD_W-1:0] flash_data,
    output logic                   config_status_n,
    output logic                   config_done_flag,
    // Observed stream
    output logic      [WORD_W-1:0] first_word,
    output logic      [7:0]        n_words
);
    logic [WORD_W-1:0] sh;
    int                nb;
    initial begin
        flash_data = '0;
        config_status_n = 1'b1;
        config_done_flag = 1'b0;
        first_word = '0;
        n_words = '0;
        nb = 0;
    end
    // word content per address; deselected bus keeps changing
    always @(posedge pclk) begin
        if (!flash.ce_n && !flash.oe_n)
            flash_data <= flash.addr[23:8] ^ flash.addr[15:0];
        else
            flash_data <= ~flash_data;
    end
    // status low in request, high after release
    always begin
        @(negedge cfg.request_n);
        config_status_n = 1'b0;
        config_done_flag = 1'b0;
        n_words = '0;
        nb = 0;
        @(posedge cfg.request_n);
        #400;
        config_status_n = 1'b1;
    end
    // bit capture, done after the set word count
    always @(posedge cfg.bit_clock) begin
        sh = {cfg.serial_data, sh[WORD_W-1:1]};
        nb++;
        if (nb == WORD_W) begin
            nb = 0;
            if (n_words == 0)
                first_word = sh;
            n_words++;
            if (n_words == done_words)
                config_done_flag = 1'b1;
        end
    end
endmodule : fpga_flash_model
`default_nettype wire

// ### tb.sv
// Self-checking bench for the flash image loader
`timescale 1ns/1ps
`default_nettype none
module tb import loader_pkg::*;;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]        paddr, done_words, n_words;
    logic [31:0]       pwdata, prdata, r;
    logic              ld_n, sel_n, sw, jmp_n, ind0, ind1, ind2, act, err, fac, st_n, dn, e;
    logic [WORD_W-1:0] fdata, first_word;
    flash_req_t        flash;
    cfg_pins_t         cfg;
    jtag_pins_t        jtag;
    int                n_errors, tests_run, low_cyc, req_w, cyc;

    flash_image_loader #(.PAGE_WORDS(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .image_load_button_n(ld_n),
        .image_select_button_n(sel_n), .boot_image_switch(sw), .jtag_takeover_jumper_n(jmp_n),
        .page_indicator_0_n(ind0), .page_indicator_1_n(ind1), .page_indicator_2_n(ind2),
        .load_active_led(act), .load_error_led(err), .factory_led(fac), .flash(flash),
        .flash_data(fdata), .cfg(cfg), .config_status_n(st_n), .config_done_flag(dn),
        .jtag(jtag), .jtag_tdo(jtag.tdi));
    fpga_flash_model model (.pclk(pclk), .flash(flash), .cfg(cfg), .done_words(done_words),
        .flash_data(fdata), .config_status_n(st_n), .config_done_flag(dn),
        .first_word(first_word), .n_words(n_words));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Length of the last request pulse
    always @(posedge pclk) begin
        if (!cfg.request_n)
            low_cyc <= low_cyc + 1;
        else begin
            if (low_cyc != 0)
                req_w <= low_cyc;
            low_cyc <= 0;
        end
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, '0);
        chk(n, x, r);
    endtask : rd
    task automatic wait_act(input logic v);
        for (int i = 0; i < 3000 && act !== v; i++)
            @(posedge pclk);
        chk("load_active_led", v, act);
    endtask : wait_act
    task automatic press(input logic s);
        if (s)
            sel_n <= 1'b0;
        else
            ld_n <= 1'b0;
        repeat (4) @(posedge pclk);
        sel_n <= 1'b1;
        ld_n <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask : press
    task automatic load_done(input logic [FLASH_AW-1:0] base);
        wait_act(1'b1);
        wait_act(1'b0);
        chk("first_word", base[23:8] ^ base[15:0], first_word);
    endtask : load_done
    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, sw} = '0;
        {ld_n, sel_n, jmp_n} = 3'h7;
        {n_errors, tests_run, low_cyc, req_w, cyc} = '0;
        done_words = 8'h02;
        repeat (10) @(posedge pclk);
        chk("indicators", IND_RESET, {ind2, ind1, ind0});
        chk("leds", 3'h0, {act, err, fac});
        presetn <= 1'b1;
        apb(1'b1, REG_IRQ_MASK, 32'h3);
        load_done(PAGE0_BASE);
        chk("factory_led", 1'b1, fac);
        chk("request width", REQ_LOW_CYC, req_w);
        chk("words", 8'h02, n_words);
        @(posedge pclk);
        chk("irq", 1'b1, irq);
        rd("status", REG_STATUS, 32'h104);
        rd("irq_stat", REG_IRQ_STAT, 32'h1);
        rd("irq_stat cleared", REG_IRQ_STAT, 32'h0);
        chk("irq off", 1'b0, irq);
        rd("unmapped", 8'h20, 32'h0);
        chk("pslverr", 1'b1, e);
        press(1'b1);
        chk("indicators", 3'h5, {ind2, ind1, ind0});
        apb(1'b1, REG_IRQ_MASK, 32'h0);
        press(1'b0);
        load_done(PAGE1_BASE);
        chk("factory_led", 1'b0, fac);
        chk("irq masked", 1'b0, irq);
        rd("irq_stat", REG_IRQ_STAT, 32'h1);
        done_words = 8'h00;
        apb(1'b1, REG_CTRL, 32'h1);
        wait_act(1'b1);
        wait_act(1'b0);
        chk("load_error_led", 1'b1, err);
        apb(1'b1, REG_IRQ_MASK, 32'h2);
        repeat (2) @(posedge pclk);
        chk("irq error", 1'b1, irq);
        rd("irq_stat", REG_IRQ_STAT, 32'h2);
        jmp_n <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("jtag oe", 1'b1, jtag.oe);
        apb(1'b1, REG_JTAG, 32'h7);
        @(posedge pclk);
        chk("jtag pins", 3'h7, {jtag.tck, jtag.tms, jtag.tdi});
        rd("jtag tdo", REG_JTAG, 32'hf);
        done_words = 8'h02;
        sw <= 1'b1;
        press(1'b0);
        wait_act(1'b1);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset leds", 3'h0, {act, err, fac});
        chk("reset indicators", IND_RESET, {ind2, ind1, ind0});
        presetn <= 1'b1;
        load_done(PAGE1_BASE);
        chk("factory_led", 1'b0, fac);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
